// ===== logic/scst_cfg.svh
// constants for the sample capture serial transmitter
`ifndef SCST_CFG_SVH
`define SCST_CFG_SVH
`define SCST_CFG_RESET 8'h00
`define SCST_BIT_RATE 0
`define SCST_BIT_SIZE 1
`define SCST_BIT_GAP 2
`define SCST_BIT_SET_LO 3
`define SCST_BIT_SET_HI 4
`define SCST_BIT_POL 5
`define SCST_SET_FULL 2'h0
`define SCST_SET_VI 2'h1
`define SCST_SET_PWR 2'h2
`define SCST_CLK_NS 10
`define SCST_SCLK_FAST_NS 125
`define SCST_SCLK_SLOW_NS 250
`define SCST_SCLK_FAST_CYC (`SCST_SCLK_FAST_NS / `SCST_CLK_NS)
`define SCST_SCLK_SLOW_CYC (`SCST_SCLK_SLOW_NS / `SCST_CLK_NS)
`define SCST_GAP_SCLK 7
`define SCST_SAMPLE_US 125
`define SCST_LIMIT_FAST (`SCST_SAMPLE_US * 1000 / `SCST_SCLK_FAST_NS)
`define SCST_LIMIT_SLOW (`SCST_SAMPLE_US * 1000 / `SCST_SCLK_SLOW_NS)
`define SCST_ZERO_IDX 6
`define SCST_PWR_FIRST 7
`define SCST_LAST_FULL 15
`endif

// ===== logic/scst_pkg.sv
// types of the sample capture serial transmitter
package scst_pkg;
	typedef enum logic [1:0] {
		SCST_IDLE = 2'b00,
		SCST_SHIFT = 2'b01,
		SCST_GAP = 2'b10
	} scst_state_t;
endpackage

// ===== logic/scst_tx.sv
// sample capture serial transmitter: config register and shift engine
// Overview of operation
// RQ1: code 10 sends nine power words: apparent, active, reactive, phases A-C.
// RQ2: code 11 behaves exactly like code 00, full word set.
// RQ3: polarity bit 5 low: select active low, high while idle.
// RQ4: polarity bit 5 high: select active high, low while idle.
// RQ5: select stays asserted for the whole transfer including gaps.
// RQ6: config bits 7 and 6 have no effect on transmission.
// RQ7: gap bit clear: one bit per falling clock edge, no pauses.
// RQ8: gap bit set, 32-bit packages: 7 idle clocks after each word.
// RQ9: gap bit set, 8-bit packages: 7 idle clocks after each byte.
// RQ10: transfer shorter than 125 us starts every 8 kHz sample cycle.
// RQ11: longer transfer sends only in first of two sample cycles.
// RQ12: config bit 0 picks 8 MHz (0) or 4 MHz (1) serial clock.
// RQ13: bit 1 picks 32/8-bit packages; samples sign-extended, MSB first.
// RQ14: code 00 six samples, zero word, nine powers; 01 six plus zero.
// RQ15: port idle after reset until enabled, and only with I2C host.
`include "scst_cfg.svh"
module scst_tx (
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic cfg_wr_en,
	input wire logic [7:0] cfg_wr_data,
	output logic [7:0] cfg_rd_data,
	input wire logic capture_port_enable,
	input wire logic i2c_host_selected,
	input wire logic sample_update,
	input wire logic [23:0] phase_a_current_sample,
	input wire logic [23:0] phase_a_voltage_sample,
	input wire logic [23:0] phase_b_current_sample,
	input wire logic [23:0] phase_b_voltage_sample,
	input wire logic [23:0] phase_c_current_sample,
	input wire logic [23:0] phase_c_voltage_sample,
	input wire logic [23:0] phase_a_apparent_power,
	input wire logic [23:0] phase_b_apparent_power,
	input wire logic [23:0] phase_c_apparent_power,
	input wire logic [23:0] phase_a_active_power,
	input wire logic [23:0] phase_b_active_power,
	input wire logic [23:0] phase_c_active_power,
	input wire logic [23:0] phase_a_reactive_power,
	input wire logic [23:0] phase_b_reactive_power,
	input wire logic [23:0] phase_c_reactive_power,
	output logic capture_serial_clock,
	output logic capture_data_out,
	output logic capture_select_out,
	output logic capture_select_active
);
	// serial clock lengths in system cycles
	localparam logic [4:0] FAST_CYC = 5'(`SCST_SCLK_FAST_CYC);
	localparam logic [4:0] SLOW_CYC = 5'(`SCST_SCLK_SLOW_CYC);

	logic [7:0] capture_port_config_reg;
	logic [23:0] word_reg [0:15];
	scst_pkg::scst_state_t state_reg;
	logic [4:0] div_reg;
	logic [4:0] period_reg;
	logic [4:0] bit_idx_reg;
	logic [3:0] word_idx_reg;
	logic [3:0] last_word_reg;
	logic [2:0] gap_cnt_reg;
	logic gap_en_reg;
	logic size8_reg;
	logic [31:0] shift_reg;
	logic phase_reg;
	logic data_reg;
	logic sclk_reg;
	logic sel_reg;
	logic port_on;
	logic long_xfer;
	logic start;
	logic period_end;
	logic boundary;
	logic [1:0] set_sel;
	logic last_bit;
	logic leave_shift;
	logic gap_done;

	// reserved code 11 folds onto 00, so only three sets exist
	function automatic logic [1:0] set_of(input logic [7:0] c);
		set_of = c[`SCST_BIT_SET_HI:`SCST_BIT_SET_LO]; // RQ6
		if (set_of == 2'h3)
			set_of = `SCST_SET_FULL; // RQ2
	endfunction

	// serial clocks needed for one transfer under a setting
	function automatic logic [11:0] xfer_sclk(input logic [7:0] c);
		logic [11:0] words;
		logic [11:0] pkgs;
		words = 12'd16;
		pkgs = 12'd0;
		case (set_of(c))
			`SCST_SET_VI: words = 12'd7;
			`SCST_SET_PWR: words = 12'd9;
			default: words = 12'd16;
		endcase
		pkgs = c[`SCST_BIT_SIZE] ? 12'(words * 12'd4) : words;
		xfer_sclk = 12'(words * 12'd32);
		if (c[`SCST_BIT_GAP])
			xfer_sclk = 12'(xfer_sclk + (pkgs - 12'd1) * 12'(`SCST_GAP_SCLK));
	endfunction

	// the port only runs with the I2C host; the flag itself lives upstream
	assign port_on = capture_port_enable & i2c_host_selected; // RQ15
	assign set_sel = set_of(capture_port_config_reg);
	// limit is 125 us expressed in serial clocks at the chosen rate
	assign long_xfer = capture_port_config_reg[`SCST_BIT_RATE] ?
		(xfer_sclk(capture_port_config_reg) > 12'(`SCST_LIMIT_SLOW)) :
		(xfer_sclk(capture_port_config_reg) > 12'(`SCST_LIMIT_FAST));
	// a sample update that finds the port busy is skipped
	assign start = sample_update & port_on &
		(state_reg == scst_pkg::SCST_IDLE) &
		(~long_xfer | ~phase_reg); // RQ10 RQ11
	assign period_end = (div_reg == period_reg - 5'd1);
	// package edge: every byte in 8-bit mode, else every word
	assign boundary = gap_en_reg &
		(size8_reg ? (bit_idx_reg[2:0] == 3'h7) : (bit_idx_reg == 5'd31));
	// period that closes the transfer, or one followed by a gap
	assign last_bit = (bit_idx_reg == 5'd31) && (word_idx_reg == last_word_reg);
	assign leave_shift = last_bit | boundary;
	assign gap_done = (gap_cnt_reg == 3'(`SCST_GAP_SCLK - 1));
	assign cfg_rd_data = capture_port_config_reg;
	assign capture_serial_clock = sclk_reg;
	assign capture_data_out = data_reg;
	assign capture_select_out = sel_reg;
	assign capture_select_active = (state_reg != scst_pkg::SCST_IDLE);

	// configuration byte; all eight bits read back
	always_ff @(posedge clk) begin
		if (reset)
			capture_port_config_reg <= `SCST_CFG_RESET;
		else if (clk_en && cfg_wr_en)
			capture_port_config_reg <= cfg_wr_data;
	end

	// sample cycle parity, restarted whenever the port is off
	always_ff @(posedge clk) begin
		if (reset)
			phase_reg <= 1'b0;
		else if (clk_en) begin
			if (!port_on)
				phase_reg <= 1'b0;
			else if (sample_update)
				phase_reg <= ~phase_reg; // RQ11
		end
	end

	// snapshot of all words at start so a long transfer stays coherent
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < 16; i++)
				word_reg[i] <= 24'h000000;
		end else if (clk_en && start) begin
			word_reg[0] <= phase_a_current_sample; // RQ14
			word_reg[1] <= phase_a_voltage_sample;
			word_reg[2] <= phase_b_current_sample;
			word_reg[3] <= phase_b_voltage_sample;
			word_reg[4] <= phase_c_current_sample;
			word_reg[5] <= phase_c_voltage_sample;
			word_reg[`SCST_ZERO_IDX] <= 24'h000000;
			word_reg[7] <= phase_a_apparent_power; // RQ1
			word_reg[8] <= phase_b_apparent_power;
			word_reg[9] <= phase_c_apparent_power;
			word_reg[10] <= phase_a_active_power;
			word_reg[11] <= phase_b_active_power;
			word_reg[12] <= phase_c_active_power;
			word_reg[13] <= phase_a_reactive_power;
			word_reg[14] <= phase_b_reactive_power;
			word_reg[15] <= phase_c_reactive_power;
		end
	end

	// serial clock divider; low half first so data changes on the fall
	always_ff @(posedge clk) begin
		if (reset) begin
			div_reg <= 5'd0;
			sclk_reg <= 1'b1;
		end else if (clk_en) begin
			if (state_reg != scst_pkg::SCST_IDLE && !start) begin
				div_reg <= period_end ? 5'd0 : 5'(div_reg + 5'd1);
				// clock rests high through gaps and after the last bit,
				// so the receiver never sees a stray falling edge
				if (period_end)
					sclk_reg <= (state_reg == scst_pkg::SCST_SHIFT) ?
						leave_shift : !gap_done; // RQ8 RQ9
				else
					sclk_reg <= (state_reg != scst_pkg::SCST_SHIFT) ||
						(div_reg + 5'd1 >= period_reg >> 1);
			end else begin
				div_reg <= 5'd0;
				sclk_reg <= ~start;
			end
		end
	end

	// transfer sequencer: words, packages and gaps
	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= scst_pkg::SCST_IDLE;
			period_reg <= FAST_CYC;
			bit_idx_reg <= 5'd0;
			word_idx_reg <= 4'd0;
			last_word_reg <= 4'd0;
			gap_cnt_reg <= 3'd0;
			gap_en_reg <= 1'b0;
			size8_reg <= 1'b0;
		end else if (clk_en) begin
			if (start) begin
				state_reg <= scst_pkg::SCST_SHIFT;
				// rate, gap, size and word set are frozen for the whole transfer; polarity stays live
				period_reg <= capture_port_config_reg[`SCST_BIT_RATE] ?
					SLOW_CYC : FAST_CYC; // RQ12
				gap_en_reg <= capture_port_config_reg[`SCST_BIT_GAP]; // RQ7
				size8_reg <= capture_port_config_reg[`SCST_BIT_SIZE]; // RQ13
				bit_idx_reg <= 5'd0;
				word_idx_reg <= (set_sel == `SCST_SET_PWR) ?
					4'(`SCST_PWR_FIRST) : 4'd0; // RQ1
				last_word_reg <= (set_sel == `SCST_SET_VI) ?
					4'(`SCST_ZERO_IDX) : 4'(`SCST_LAST_FULL); // RQ14 RQ2
			end else if (!port_on) begin
				// disabling aborts at once and returns pins to idle
				state_reg <= scst_pkg::SCST_IDLE; // RQ15
			end else if (period_end) begin
				case (state_reg)
					scst_pkg::SCST_SHIFT: begin
						bit_idx_reg <= 5'(bit_idx_reg + 5'd1);
						if (bit_idx_reg == 5'd31)
							word_idx_reg <= 4'(word_idx_reg + 4'd1);
						if (bit_idx_reg == 5'd31 && word_idx_reg == last_word_reg)
							state_reg <= scst_pkg::SCST_IDLE; // RQ5
						else if (boundary) begin
							state_reg <= scst_pkg::SCST_GAP; // RQ8 RQ9
							gap_cnt_reg <= 3'd0;
						end
					end
					scst_pkg::SCST_GAP: begin
						gap_cnt_reg <= 3'(gap_cnt_reg + 3'd1);
						if (gap_cnt_reg == 3'(`SCST_GAP_SCLK - 1))
							state_reg <= scst_pkg::SCST_SHIFT; // RQ8 RQ9
					end
					default: state_reg <= scst_pkg::SCST_IDLE;
				endcase
			end
		end
	end

	// data line: next bit placed at the start of each shift period
	always_ff @(posedge clk) begin
		if (reset) begin
			shift_reg <= 32'h00000000;
			data_reg <= 1'b1;
		end else if (clk_en) begin
			if (start) begin
				shift_reg <= 32'h00000000;
				data_reg <= 1'b1;
			end else if (state_reg == scst_pkg::SCST_SHIFT && div_reg == 5'd0) begin
				if (bit_idx_reg == 5'd0) begin
					// sign extension of the 24-bit sample, MSB first
					data_reg <= word_reg[word_idx_reg][23]; // RQ13 RQ7
					shift_reg <= {{8{word_reg[word_idx_reg][23]}},
						word_reg[word_idx_reg]} << 1;
				end else begin
					data_reg <= shift_reg[31]; // RQ7
					shift_reg <= shift_reg << 1;
				end
			end else if (state_reg == scst_pkg::SCST_IDLE)
				data_reg <= 1'b1;
		end
	end

	// select pin follows the busy state in the chosen polarity
	always_ff @(posedge clk) begin
		if (reset)
			sel_reg <= 1'b1;
		else if (clk_en) begin
			if (capture_port_config_reg[`SCST_BIT_POL])
				sel_reg <= start | capture_select_active; // RQ4 RQ5
			else
				sel_reg <= ~(start | capture_select_active); // RQ3 RQ5
		end
	end
endmodule // scst_tx

// ===== sim/scst_tx_properties.sv
// checker: pin-level properties of the capture transmitter
module scst_tx_properties (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] cfg_rd_data,
	input wire logic capture_port_enable,
	input wire logic i2c_host_selected,
	input wire logic capture_serial_clock,
	input wire logic capture_data_out,
	input wire logic capture_select_out,
	input wire logic capture_select_active
);
	timeunit 1ns;
	timeprecision 1ns;
	// short aliases keep each property to one line
	wire sa = capture_select_active;
	wire so = capture_select_out;
	wire sc = capture_serial_clock;
	wire sd = capture_data_out;
	wire [7:0] cf = cfg_rd_data;
	wire en = capture_port_enable && i2c_host_selected;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	property p_ipol;
		!sa [*2] ##0 $stable(cf) |-> so == !cf[5];
	endproperty
	a_ipol: assert property (p_ipol) else $error("idle select");
	property p_apol;
		sa && $past(sa) && $stable(cf) |-> so == cf[5];
	endproperty
	a_apol: assert property (p_apol) else $error("busy select");
	property p_idle;
		!sa [*2] |-> sc && sd;
	endproperty
	a_idle: assert property (p_idle) else $error("idle lines");
	property p_fast;
		$fell(sc) && !cf[0] |-> !sc [*6] ##1 sc;
	endproperty
	a_fast: assert property (p_fast) else $error("fast clock");
	property p_slow;
		$fell(sc) && cf[0] |-> ##11 !sc ##1 sc;
	endproperty
	a_slow: assert property (p_slow) else $error("slow clock");
	property p_flow;
		$rose(sc) && sa && !cf[2] && !cf[0] |-> (##6 !sc) or (##7 !sa);
	endproperty
	a_flow: assert property (p_flow) else $error("pause");
	property p_dat;
		sa && $changed(sd) |-> !sc;
	endproperty
	a_dat: assert property (p_dat) else $error("data edge");
	property p_off;
		!en |=> !sa;
	endproperty
	a_off: assert property (p_off) else $error("disabled");
endmodule // scst_tx_properties
bind scst_tx scst_tx_properties scst_tx_properties_i (.clk(clk),
	.reset(reset), .cfg_rd_data(cfg_rd_data),
	.capture_port_enable(capture_port_enable),
	.i2c_host_selected(i2c_host_selected),
	.capture_serial_clock(capture_serial_clock),
	.capture_data_out(capture_data_out),
	.capture_select_out(capture_select_out),
	.capture_select_active(capture_select_active));

// ===== sim/scst_rx_model.sv
// far-side serial receiver collecting the bit stream
module scst_rx_model (
	input wire logic sclk,
	input wire logic sdata,
	input wire logic sel,
	input wire logic pol
);
	timeunit 1ns;
	timeprecision 1ns;
	logic rx_q [$];
	// sample on the rising clock only while selected, as a slave does
	always @(posedge sclk)
		if (sel == pol)
			rx_q.push_back(sdata);
endmodule // scst_rx_model

// ===== sim/scst_tx_tb_top.sv
// testbench: drives the capture transmitter and checks its stream
module scst_tx_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, reset, cfg_wr_en, en, host, upd, sclk, sdata, sel, act;
	logic [7:0] cfg_wr_data, cfg_rd_data;
	logic [23:0] v [15];
	int n_fail, tests_run, cyc;
	scst_tx scst_tx_i (.clk(clk), .reset(reset), .clk_en(1'b1),
		.cfg_wr_en(cfg_wr_en), .cfg_wr_data(cfg_wr_data),
		.cfg_rd_data(cfg_rd_data), .capture_port_enable(en),
		.i2c_host_selected(host), .sample_update(upd),
		.phase_a_current_sample(v[0]), .phase_a_voltage_sample(v[1]),
		.phase_b_current_sample(v[2]), .phase_b_voltage_sample(v[3]),
		.phase_c_current_sample(v[4]), .phase_c_voltage_sample(v[5]),
		.phase_a_apparent_power(v[6]), .phase_b_apparent_power(v[7]),
		.phase_c_apparent_power(v[8]), .phase_a_active_power(v[9]),
		.phase_b_active_power(v[10]), .phase_c_active_power(v[11]),
		.phase_a_reactive_power(v[12]), .phase_b_reactive_power(v[13]),
		.phase_c_reactive_power(v[14]), .capture_serial_clock(sclk),
		.capture_data_out(sdata), .capture_select_out(sel),
		.capture_select_active(act));
	scst_rx_model scst_rx_model_i (.sclk(sclk), .sdata(sdata),
		.sel(sel), .pol(cfg_rd_data[5]));
	// free-running 100 MHz clock
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task automatic summarize;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// bounded wait for the busy flag; cyc is the time it took
	task automatic wait_act(input logic lvl, input int lim);
		cyc = 0;
		while (act !== lvl) begin
			@(negedge clk);
			cyc++;
			if (cyc > lim) begin
				$display("ERROR %0t no handshake", $time);
				n_fail++;
				summarize();
			end
		end
	endtask
	task automatic wr(input logic [7:0] c);
		cfg_wr_data = c;
		cfg_wr_en = 1;
		@(negedge clk) cfg_wr_en = 0;
		check(cfg_rd_data, c);
	endtask
	// program, fire one update, time the whole transfer
	task automatic run(input logic [7:0] c);
		wr(c);
		scst_rx_model_i.rx_q.delete();
		upd = 1;
		@(negedge clk) upd = 0;
		wait_act(1'b1, 4);
		wait_act(1'b0, 20000);
		@(negedge clk);
	endtask
	// rebuild words MSB first; slot 6 is the zero word
	task automatic cmp(input int first, input int n);
		logic [31:0] w;
		int j;
		check(scst_rx_model_i.rx_q.size(), n * 32);
		for (int k = first; k < first + n; k++) begin
			for (int b = 0; b < 32; b++)
				w[31 - b] = scst_rx_model_i.rx_q[(k - first) * 32 + b];
			j = k < 6 ? k : k - 1;
			check(w, k == 6 ? 32'h0 : {{8{v[j][23]}}, v[j]});
		end
	endtask
	// one update, then sit out the sample cycle; got is bits received
	task automatic period(input int span, output int got);
		scst_rx_model_i.rx_q.delete();
		upd = 1;
		@(negedge clk) upd = 0;
		repeat (span - 1) @(negedge clk);
		got = scst_rx_model_i.rx_q.size();
	endtask
	task automatic t_sets;
		check(sel, 1'b1);
		run(8'h08);
		cmp(0, 7);
		run(8'h10);
		cmp(7, 9);
		check((cyc + 6) / 12, 288);
		$display("t_sets done");
	endtask
	task automatic t_gaps;
		run(8'h14);
		check((cyc + 6) / 12, 344);
		run(8'h16);
		check((cyc + 6) / 12, 533);
		cmp(7, 9);
		$display("t_gaps done");
	endtask
	task automatic t_pol;
		run(8'h29);
		check(sel, 1'b0);
		check((cyc + 12) / 25, 224);
		cmp(0, 7);
		$display("t_pol done");
	endtask
	// pacing; the long case is stretched so a skipped update finds idle
	task automatic t_pace;
		int got;
		wr(8'hd8);
		repeat (2) begin
			period(12500, got);
			check(got, 512);
		end
		cmp(0, 16);
		host = 0;
		period(20, got);
		check(act, 1'b0);
		host = 1;
		wr(8'h01);
		period(13000, got);
		check(got, 512);
		period(13000, got);
		check(got, 0);
		period(13000, got);
		check(got, 512);
		$display("t_pace done");
	endtask
	// reset, scenarios, verdict
	initial begin
		{reset, cfg_wr_en, upd, en, host} = 5'b10011;
		cfg_wr_data = 8'h00;
		n_fail = 0;
		tests_run = 0;
		for (int i = 0; i < 15; i++)
			v[i] = 24'(24'h0a5a51 + 24'h1c3b29 * i);
		repeat (6) @(negedge clk);
		reset = 0;
		t_sets();
		t_gaps();
		t_pol();
		t_pace();
		summarize();
	end
endmodule // scst_tx_tb_top
